/* File: shared/ffl_pkg.sv */
`default_nettype none
package ffl_pkg;
	localparam int DATA_W = 16;
	localparam int DEPTH = 64;
	localparam int PTR_W = 6;
	localparam int CNT_W = 7;
	localparam int EVT_W = 4;
	// Latencies in hclk cycles
	localparam int RD_DATA_LAT = 4;
	localparam int RD_CFG_LAT = 4;
	localparam int MB_LAT = 2;
	localparam int FULL_REL_LAT = 8;
	// Write visibility; 8 + 1 cycles stays inside the 24 and 26 cycle budgets
	localparam int VIS_LAT = 8;
	localparam int FULL_SET_MAX = 4;
	localparam int EMPTY_REL_MAX = 24;
	localparam int INIT_MAX = 26;
	localparam logic [5:0] PRS_REC = 6'h20;
	localparam logic [10:0] LOCK_CYC = 11'h400;
	localparam logic [CNT_W-1:0] CNT_FULL = 7'h40;
	localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
	// Register map, byte offsets
	localparam logic [7:0] REG_CFG = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_MASK = 8'h08;
	localparam logic [7:0] REG_LEVEL = 8'h0c;
	localparam logic [DATA_W-1:0] CFG_RST = 16'h0000;
	localparam logic [EVT_W-1:0] MASK_RST = 4'h0;
	// Status bits
	localparam int ST_OVF = 0;
	localparam int ST_UNF = 1;
	localparam int ST_FULL = 2;
	localparam int ST_EMPTY = 3;
	// Level register fields
	localparam int LV_VIS = 0;
	localparam int LV_OCC = 8;
	localparam int LV_EMPTY = 16;
	localparam int LV_FULL = 17;
	localparam int LV_READY = 18;
	localparam int HTRANS_ACT = 1;
	typedef struct packed {
		logic en_n;
		logic [DATA_W-1:0] data;
	} ffl_wr_t;
	typedef struct packed {
		logic en_n;
		logic config_load_select_n;
	} ffl_rdreq_t;
	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] data;
	} ffl_rdo_t;
	typedef struct packed {
		logic full_indicator_n;
		logic empty_indicator_n;
	} ffl_flags_t;
	function automatic logic [CNT_W-1:0] ffl_step(logic [CNT_W-1:0] c, logic inc, logic dec);
		return c + {6'h00, inc} - {6'h00, dec};
	endfunction
endpackage
`default_nettype wire

/* File: rtl/ffl_frame_fifo.sv */
// Function
// R01 - A data read strobe yields the next stored word four cycles later.
// R02 - A read strobe with load select yields the configuration word four cycles later.
// R03 - After going empty, a new word becomes readable within 26 cycles.
// R04 - Full indicator drops within four cycles of the filling write.
// R05 - Empty indicator drops with no extra delay when the last word leaves.
// R06 - Full indicator rises exactly eight cycles after a read frees space.
// R07 - Empty indicator rises within 24 cycles of a write into an empty buffer.
// R08 - Normal operation resumes 32 cycles after partial reset is released.
// R09 - With mailbox selected, a written word reaches the read port two cycles later.
// R10 - The latency figures assume equal read and write clock rates.
// R11 - Far side waits 1024 cycles of clock lock before using the ports.
// R12 - Far side waits 2 ms after supplies settle before any activity.
// R13 - Full and empty indicators are active low.
`default_nettype none
module ffl_frame_fifo
	import ffl_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic irq,
	// Write and read ports
	input wire ffl_pkg::ffl_wr_t wr,
	input wire ffl_pkg::ffl_rdreq_t rd,
	output ffl_pkg::ffl_rdo_t rdo,
	output ffl_pkg::ffl_flags_t flags,
	// Mode and partial reset
	input wire logic mailbox_select,
	input wire logic partial_reset_in
);
	import ffl_pkg::*;

	typedef struct packed {
		logic [PTR_W-1:0] wptr;
		logic [PTR_W-1:0] rptr;
		logic [CNT_W-1:0] vis;
		logic [CNT_W-1:0] occ;
		logic [VIS_LAT-1:0] vis_pipe;
		logic [FULL_REL_LAT-1:0] ret_pipe;
		logic [RD_DATA_LAT-1:0] dv;
		logic [RD_DATA_LAT-1:0][DATA_W-1:0] dp;
		logic [MB_LAT-1:0] mv;
		logic [MB_LAT-1:0][DATA_W-1:0] mp;
		logic [10:0] lock_cnt;
		logic [5:0] rec_cnt;
		logic ap_wr;
		logic [7:0] ap_addr;
		logic [DATA_W-1:0] cfg;
		logic [EVT_W-1:0] stat;
		logic [EVT_W-1:0] mask;
		logic [31:0] hrdata;
		logic hreadyout;
		logic irq;
		ffl_rdo_t rdo;
		ffl_flags_t flags;
	} ffl_state_t;

	localparam ffl_state_t ST_RST = '{
		wptr: '0, rptr: '0, vis: '0, occ: '0, vis_pipe: '0, ret_pipe: '0,
		dv: '0, dp: '0, mv: '0, mp: '0, lock_cnt: '0, rec_cnt: '0,
		ap_wr: 1'b0, ap_addr: '0, cfg: CFG_RST, stat: '0, mask: MASK_RST,
		hrdata: '0, hreadyout: 1'b1, irq: 1'b0, rdo: '0, flags: '0
	};

	ffl_state_t s_ff;
	ffl_state_t nxt_s;
	logic [DATA_W-1:0] mem [DEPTH];
	logic ready;
	logic acc_w;
	logic acc_mb;
	logic acc_r;
	logic pop;
	logic ap_take;
	logic [EVT_W-1:0] evt;
	logic [EVT_W-1:0] clr;
	logic [DATA_W-1:0] d0;
	logic [31:0] rmux;

	// Ports only act after clock lock and partial reset recovery
	assign ready = (s_ff.lock_cnt == LOCK_CYC) && (s_ff.rec_cnt == '0); // see R08 see R11
	// A single clock drives both ports, so the 1:1 ratio always holds
	assign acc_w = ready && !wr.en_n && !mailbox_select && (s_ff.occ != CNT_FULL); // see R10
	assign acc_mb = ready && !wr.en_n && mailbox_select;
	// Reads are parked in mailbox mode; the read port carries mailbox words then
	assign acc_r = ready && !rd.en_n && !mailbox_select
		&& (!rd.config_load_select_n || (s_ff.vis != '0));
	assign pop = acc_r && rd.config_load_select_n;
	assign d0 = rd.config_load_select_n ? mem[s_ff.rptr] : s_ff.cfg; // see R02
	assign ap_take = hsel && hready && htrans[HTRANS_ACT];
	assign hreadyout = s_ff.hreadyout;
	assign hrdata = s_ff.hrdata;
	assign hresp = 1'b0;
	assign irq = s_ff.irq;
	assign rdo = s_ff.rdo;
	assign flags = s_ff.flags;

	always_comb begin
		evt = '0;
		evt[ST_OVF] = ready && !wr.en_n && !mailbox_select && (s_ff.occ == CNT_FULL);
		evt[ST_UNF] = ready && !rd.en_n && !mailbox_select && rd.config_load_select_n
			&& (s_ff.vis == '0);
		// A release landing in the same cycle keeps one slot free
		evt[ST_FULL] = acc_w && (s_ff.occ == CNT_FULL - CNT_ONE)
			&& !s_ff.ret_pipe[FULL_REL_LAT-1];
		evt[ST_EMPTY] = pop && (s_ff.vis == CNT_ONE) && !s_ff.vis_pipe[VIS_LAT-1];
	end

	always_comb begin
		nxt_s = s_ff;
		clr = '0;
		rmux = '0;
		if (s_ff.lock_cnt != LOCK_CYC) begin
			nxt_s.lock_cnt = s_ff.lock_cnt + 11'h001; // see R11
		end
		// Word pointers and counts
		if (acc_w) begin
			nxt_s.wptr = s_ff.wptr + 6'h01;
		end
		if (pop) begin
			nxt_s.rptr = s_ff.rptr + 6'h01; // see R01
		end
		// A written word becomes readable only after the visibility delay
		nxt_s.vis_pipe = {s_ff.vis_pipe[VIS_LAT-2:0], acc_w}; // see R03 see R07
		nxt_s.vis = ffl_step(s_ff.vis, s_ff.vis_pipe[VIS_LAT-1], pop); // see R05
		// Freed space returns to the writer side only after the release delay
		nxt_s.ret_pipe = {s_ff.ret_pipe[FULL_REL_LAT-2:0], pop}; // see R06
		nxt_s.occ = ffl_step(s_ff.occ, acc_w, s_ff.ret_pipe[FULL_REL_LAT-1]); // see R04
		// Read data pipeline
		nxt_s.dv = {s_ff.dv[RD_DATA_LAT-2:0], acc_r}; // see R01 see R02
		nxt_s.dp = {s_ff.dp[RD_DATA_LAT-2:0], d0};
		nxt_s.mv = {s_ff.mv[MB_LAT-2:0], acc_mb}; // see R09
		nxt_s.mp = {s_ff.mp[MB_LAT-2:0], wr.data};
		if (s_ff.mv[MB_LAT-1]) begin
			nxt_s.rdo = '{valid: 1'b1, data: s_ff.mp[MB_LAT-1]}; // see R09
		end else begin
			nxt_s.rdo = '{valid: s_ff.dv[RD_DATA_LAT-1], data: s_ff.dp[RD_DATA_LAT-1]};
		end
		// Partial reset drops stored words and restarts the recovery count
		if (partial_reset_in) begin
			nxt_s.wptr = '0;
			nxt_s.rptr = '0;
			nxt_s.vis = '0;
			nxt_s.occ = '0;
			nxt_s.vis_pipe = '0;
			nxt_s.ret_pipe = '0;
			nxt_s.dv = '0;
			nxt_s.mv = '0;
			nxt_s.rec_cnt = PRS_REC; // see R08
		end else if (s_ff.rec_cnt != '0) begin
			nxt_s.rec_cnt = s_ff.rec_cnt - 6'h01; // see R08
		end
		// Flags stay low, refusing both ports, until operation is ready
		nxt_s.flags.full_indicator_n = ready && !partial_reset_in
			&& (nxt_s.occ != CNT_FULL); // see R13 see R04
		nxt_s.flags.empty_indicator_n = ready && !partial_reset_in
			&& (nxt_s.vis != '0); // see R13 see R05
		// Bus data phase writes
		if (s_ff.ap_wr) begin
			unique case (s_ff.ap_addr)
				REG_CFG: nxt_s.cfg = hwdata[DATA_W-1:0];
				REG_MASK: nxt_s.mask = hwdata[EVT_W-1:0];
				default: ;
			endcase
		end
		nxt_s.ap_wr = ap_take && hwrite;
		nxt_s.ap_addr = haddr[7:0];
		// Reads are answered with zero wait states, so data is fetched at address phase
		if (ap_take && !hwrite) begin
			unique case (haddr[7:0])
				REG_CFG: rmux[DATA_W-1:0] = nxt_s.cfg;
				REG_STAT: begin
					rmux[EVT_W-1:0] = s_ff.stat;
					clr = s_ff.stat;
				end
				REG_MASK: rmux[EVT_W-1:0] = nxt_s.mask;
				REG_LEVEL: begin
					rmux[LV_VIS +: CNT_W] = s_ff.vis;
					rmux[LV_OCC +: CNT_W] = s_ff.occ;
					rmux[LV_EMPTY] = s_ff.flags.empty_indicator_n;
					rmux[LV_FULL] = s_ff.flags.full_indicator_n;
					rmux[LV_READY] = ready;
				end
				default: rmux = '0;
			endcase
			nxt_s.hrdata = rmux;
		end
		// A new event wins over the read that clears it
		nxt_s.stat = (s_ff.stat & ~clr) | evt;
		nxt_s.irq = |(nxt_s.stat & nxt_s.mask);
		nxt_s.hreadyout = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_ff <= ST_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Storage has no reset; pointers guard stale words
	always_ff @(posedge hclk) begin
		if (acc_w) begin
			mem[s_ff.wptr] <= wr.data;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn || partial_reset_in);

	sequence full_hold_s;
		(!flags.full_indicator_n)[*8];
	endsequence

	sequence full_back_s;
		full_hold_s ##1 flags.full_indicator_n;
	endsequence

	sequence data_out_s;
		##5 rdo.valid;
	endsequence

	sequence mb_out_s;
		##3 rdo.valid;
	endsequence

	// Registered outputs updated at edge n are seen by the sample at edge n+1
	read_data_lat_a: assert property (pop // see R01
		|-> data_out_s ##0 (rdo.data == $past(d0, 5)))
		else $error("data read not answered after four cycles");
	cfg_read_lat_a: assert property (acc_r && !rd.config_load_select_n // see R02
		|-> data_out_s ##0 (rdo.data == $past(s_ff.cfg, 5)))
		else $error("configuration read wrong or late");
	first_data_a: assert property (acc_w && s_ff.vis == '0 && s_ff.vis_pipe == '0
		|-> ##[1:22] (s_ff.vis != '0)) // see R03
		else $error("first word not readable in time");
	full_set_a: assert property (evt[ST_FULL] // see R04
		|-> ##[1:4] !flags.full_indicator_n)
		else $error("full indicator late");
	empty_set_a: assert property (evt[ST_EMPTY] |=> !flags.empty_indicator_n) // see R05
		else $error("empty indicator not immediate");
	full_release_a: assert property (pop && s_ff.occ == CNT_FULL
		|-> ##1 full_back_s) // see R06
		else $error("full indicator release not at eight cycles");
	empty_release_a: assert property (acc_w && !flags.empty_indicator_n
		|-> ##[1:24] flags.empty_indicator_n) // see R07
		else $error("empty indicator release late");
	prs_recover_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(partial_reset_in) |-> ##31 (s_ff.rec_cnt == 6'h01) ##1 ready) // see R08
		else $error("partial reset recovery not 32 cycles");
	mailbox_lat_a: assert property (acc_mb // see R09
		|-> mb_out_s ##0 (rdo.data == $past(wr.data, 3)))
		else $error("mailbox word not passed in two cycles");
	irq_level_a: assert property (s_ff.stat[ST_OVF] && s_ff.mask[ST_OVF] |-> irq)
		else $error("masked-in status not raising interrupt");
	irq_low_a: assert property (!(|(s_ff.stat & s_ff.mask)) |-> !irq)
		else $error("interrupt high with nothing unmasked");

	flags_idle_a: assert property (!ready |=> !flags.full_indicator_n // see R13
		&& !flags.empty_indicator_n)
		else $error("flags not low before ready");
	full_drop_a: assert property (evt[ST_OVF] |=> s_ff.wptr == $past(s_ff.wptr)) // see R13
		else $error("write into full buffer was stored");
	empty_drop_a: assert property (evt[ST_UNF] |=> s_ff.rptr == $past(s_ff.rptr)) // see R13
		else $error("read from empty buffer moved the pointer");
	mailbox_bypass_a: assert property (acc_mb |=> s_ff.wptr == $past(s_ff.wptr)) // see R09
		else $error("mailbox word entered storage");
	level_bound_a: assert property ((s_ff.occ <= CNT_FULL) && (s_ff.vis <= s_ff.occ)) // see R04
		else $error("level counts out of range");
	empty_flag_a: assert property (ready |=> flags.empty_indicator_n == (s_ff.vis != '0)) // see R05
		else $error("empty indicator disagrees with readable count");
	full_flag_a: assert property (ready |=> flags.full_indicator_n == (s_ff.occ != CNT_FULL)) // see R04
		else $error("full indicator disagrees with occupancy");

	ovf_sticky_a: assert property (evt[ST_OVF] |=> s_ff.stat[ST_OVF])
		else $error("overflow status lost");
	unf_sticky_a: assert property (evt[ST_UNF] |=> s_ff.stat[ST_UNF])
		else $error("underflow status lost");
	full_sticky_a: assert property (evt[ST_FULL] |=> s_ff.stat[ST_FULL])
		else $error("full status lost");
	empty_sticky_a: assert property (evt[ST_EMPTY] |=> s_ff.stat[ST_EMPTY])
		else $error("empty status lost");
	stat_clear_a: assert property (ap_take && !hwrite && (haddr[7:0] == REG_STAT)
		&& (evt == '0) |=> (s_ff.stat == '0))
		else $error("status read did not clear");
	hrdata_hold_a: assert property (!(ap_take && !hwrite) |=> $stable(hrdata))
		else $error("read data changed without a read");
	cfg_write_a: assert property (s_ff.ap_wr && (s_ff.ap_addr == REG_CFG)
		|=> (s_ff.cfg == $past(hwdata[DATA_W-1:0])))
		else $error("configuration write not stored");
	mask_write_a: assert property (s_ff.ap_wr && (s_ff.ap_addr == REG_MASK)
		|=> (s_ff.mask == $past(hwdata[EVT_W-1:0])))
		else $error("mask write not stored");

	prs_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) partial_reset_in // see R08
		|=> (s_ff.occ == '0) && (s_ff.vis == '0) && !flags.empty_indicator_n)
		else $error("partial reset left words or flag");
	prs_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) partial_reset_in // see R08
		|=> (s_ff.rec_cnt == PRS_REC))
		else $error("partial reset did not restart recovery");

endmodule // ffl_frame_fifo
`default_nettype wire

/* File: bench/ffl_far_end.sv */
`default_nettype none
module ffl_far_end
	import ffl_pkg::*;
(
	// Clock
	input wire logic hclk,
	// Device side
	input wire ffl_pkg::ffl_rdo_t rdo,
	output ffl_pkg::ffl_wr_t wr,
	output ffl_pkg::ffl_rdreq_t rd
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [DATA_W-1:0] got[$];
	initial begin
		wr = '{1'b1, 16'h0000};
		rd = '1;
	end
	// Both sides share hclk, so the latency figures apply
	always @(posedge hclk) begin
		if (rdo.valid === 1'b1) begin
			got.push_back(rdo.data);
		end
	end
	// Released data is inverted so a stale word never looks valid
	task automatic push(input int n, input logic [DATA_W-1:0] d);
		for (int i = 0; i < n; i++) begin
			@(posedge hclk);
			wr <= '{1'b0, d + i[DATA_W-1:0]};
		end
		@(posedge hclk);
		wr <= '{1'b1, ~d};
	endtask
	task automatic pull(input int n, input logic cfg_n);
		repeat (n) begin
			@(posedge hclk);
			rd <= '{1'b0, cfg_n};
		end
		@(posedge hclk);
		rd <= '1;
	endtask
endmodule // ffl_far_end
`default_nettype wire

/* File: bench/tb_top.sv */
`default_nettype none
module tb_top;
	import ffl_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk, hresetn, hwrite, hreadyout, hresp, irq, mailbox_select, partial_reset_in;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, q;
	ffl_wr_t wr;
	ffl_rdreq_t rd;
	ffl_rdo_t rdo;
	ffl_flags_t flags;
	logic [4:0] ev;
	int bad_count, checks_done, cyc, n, m;
	ffl_frame_fifo ffl_frame_fifo_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq),
		.wr(wr), .rd(rd), .rdo(rdo), .flags(flags), .mailbox_select(mailbox_select),
		.partial_reset_in(partial_reset_in));
	ffl_far_end ffl_far_end_i (.hclk(hclk), .rdo(rdo), .wr(wr), .rd(rd));
	assign ev = {flags.empty_indicator_n === 1'b0, flags.full_indicator_n === 1'b1,
		flags.full_indicator_n === 1'b0, flags.empty_indicator_n === 1'b1, rdo.valid === 1'b1};
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	task automatic end_sim();
		$display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
		if (checks_done > 0 && bad_count == 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 45000) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge hclk);
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h000000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
		chk(32'(hresp), 32'h0);
	endtask
	// Edges until event k shows; capped so a dead flag still ends the wait
	task automatic lat(input int k, output int c);
		c = 0;
		do begin
			@(posedge hclk);
			#1;
			c++;
		end while (!ev[k] && c < 60);
	endtask
	initial begin
		hresetn = 1'b0;
		htrans = 2'b00;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		mailbox_select = 1'b0;
		partial_reset_in = 1'b0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (500) @(posedge hclk);
		chk(32'(flags), 32'h0);
		// Idle ports for the power-up settling time, which also covers clock lock
		repeat (39500) @(posedge hclk);
		ahb(1'b0, REG_LEVEL, 32'h0, q);
		chk(32'(q[18:16]), 32'h6);
		ahb(1'b0, REG_CFG, 32'h0, q);
		chk(q, 32'(CFG_RST));
		ahb(1'b0, REG_MASK, 32'h0, q);
		chk(q, 32'(MASK_RST));
		ahb(1'b1, REG_CFG, 32'h5a3c, q);
		ahb(1'b0, 8'h10, 32'h0, q);
		chk(q, 32'h0);
		ffl_far_end_i.pull(1, 1'b0);
		lat(0, n);
		chk(n, 4);
		chk(32'(rdo.data), 32'h5a3c);
		ffl_far_end_i.push(1, 16'h1000);
		lat(1, n);
		chk(32'(n <= 24), 32'h1);
		ffl_far_end_i.pull(1, 1'b1);
		lat(4, m);
		chk(m, 1);
		lat(0, m);
		chk(m + 1, 4);
		chk(32'(n + 6 <= 26), 32'h1);
		chk(32'(rdo.data), 32'h1000);
		ahb(1'b1, REG_MASK, 32'h1, q);
		ahb(1'b0, REG_STAT, 32'h0, q);
		ffl_far_end_i.got.delete();
		ffl_far_end_i.push(64, 16'h2000);
		lat(2, n);
		chk(32'(n <= 4), 32'h1);
		ffl_far_end_i.push(1, 16'hffff);
		repeat (3) @(posedge hclk);
		chk(32'(irq), 32'h1);
		ahb(1'b0, REG_STAT, 32'h0, q);
		chk(q, 32'h5);
		repeat (3) @(posedge hclk);
		chk(32'(irq), 32'h0);
		ffl_far_end_i.pull(1, 1'b1);
		lat(3, n);
		chk(n, 8);
		ffl_far_end_i.pull(63, 1'b1);
		repeat (8) @(posedge hclk);
		chk(ffl_far_end_i.got.size(), 64);
		for (int i = 0; i < 64; i++) begin
			chk(32'(ffl_far_end_i.got[i]), 32'h2000 + i);
		end
		// Masked underflow must leave the interrupt low
		ahb(1'b1, REG_MASK, 32'h0, q);
		ffl_far_end_i.pull(1, 1'b1);
		repeat (3) @(posedge hclk);
		chk(32'(irq), 32'h0);
		ahb(1'b0, REG_STAT, 32'h0, q);
		chk(32'(q[1:0]), 32'h2);
		mailbox_select <= 1'b1;
		ffl_far_end_i.push(1, 16'h3c3c);
		lat(0, n);
		chk(n, 2);
		chk(32'(rdo.data), 32'h3c3c);
		@(posedge hclk);
		mailbox_select <= 1'b0;
		ffl_far_end_i.push(2, 16'h4000);
		@(posedge hclk);
		partial_reset_in <= 1'b1;
		repeat (4) @(posedge hclk);
		chk(32'(flags), 32'h0);
		partial_reset_in <= 1'b0;
		repeat (30) @(posedge hclk);
		ffl_far_end_i.got.delete();
		// First write lands one edge early and must be dropped
		ffl_far_end_i.push(1, 16'h5111);
		ffl_far_end_i.push(1, 16'h5222);
		lat(1, n);
		ffl_far_end_i.pull(2, 1'b1);
		repeat (8) @(posedge hclk);
		chk(ffl_far_end_i.got.size(), 1);
		chk(32'(ffl_far_end_i.got[0]), 32'h5222);
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
